// *** hw/rsc_pkg.sv ***
// Constants shared by the reset strap capture block.
// Assumes a single 250 MHz system clock and a synchronous active-low reset.
package rsc_pkg;

    // Clock period in picoseconds (250 MHz).
    localparam int unsigned CLK_PERIOD_PS = 4000;

    // Least low time of the external reset pin, in microseconds.
    localparam int unsigned RST_MIN_LOW_US = 1;
    localparam int unsigned RST_MIN_LOW_NS = RST_MIN_LOW_US * 1000;

    // Cycles the pin must stay low; the least time rounds up.
    localparam int unsigned RST_MIN_LOW_CYC =
        (RST_MIN_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Width of the low-time counter.
    localparam int unsigned RST_CNT_W = 8;

    // Reset values of the latched straps.
    localparam logic [1:0] FIXED_SEL_RST  = 2'h0;
    localparam logic [1:0] CFG_METHOD_RST = 2'h0;

    // Number of downstream ports on the largest package.
    localparam int unsigned PORT_CNT = 4;

    // Fixed-port selection codes.
    localparam logic [1:0] FIXED_NONE   = 2'h0;
    localparam logic [1:0] FIXED_P1     = 2'h1;
    localparam logic [1:0] FIXED_P12    = 2'h2;
    localparam logic [1:0] FIXED_P123   = 2'h3;

    // Capture sequencer states.
    typedef enum logic [1:0] {
        RSC_IDLE  = 2'b00,
        RSC_LOW   = 2'b01,
        RSC_HELD  = 2'b10
    } rsc_state_t;

endpackage

// *** hw/rsc_pin_sync.sv ***
// Two-stage synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to sys_clk.
`timescale 1ns/1ps
module rsc_pin_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_sync
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // The first stage feeds only the second stage.
    always_comb begin
        meta_d = pin_in;
        sync_d = meta_q;
    end

    // Both stages clear to zero under reset.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign pin_sync = sync_q;

endmodule

// *** hw/rsc_top.sv ***
// Captures the hub's strap pins at release of the external reset pin and
// applies them: configuration method, fixed ports, compound reporting and
// suspend LED polarity on the low fixed-port pin. Assumes the strap pins and the reset pin are
// asynchronous and that sys_clk runs free through the external reset.
`timescale 1ns/1ps
module rsc_top (
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire logic                   ext_reset_n_pin,
    input  wire logic                   fixed_port_strap_hi,
    input  wire logic                   fixed_port_strap_lo,
    input  wire logic                   config_method_strap_0,
    input  wire logic                   config_method_strap_1,
    input  wire logic                   fixed_strap_enable,
    input  wire logic [1:0]             port_count_sel,
    input  wire logic                   hs_attached,
    input  wire logic                   hub_active,
    output logic                        chip_reset,
    output logic                        straps_valid,
    output logic [1:0]                  config_method,
    output logic [1:0]                  fixed_port_select,
    output logic [rsc_pkg::PORT_CNT-1:0] fixed_port_mask,
    output logic                        compound_device,
    output logic                        upstream_speed_indicator,
    output logic                        speed_led_oe,
    output logic                        suspend_indicator,
    output logic                        suspend_led_oe
);

    import rsc_pkg::*;

    logic [4:0]           pins_s;
    logic                 rpin_s;
    logic                 hi_s;
    logic                 lo_s;
    logic                 cm0_s;
    logic                 cm1_s;
    rsc_state_t           state_q;
    rsc_state_t           state_d;
    logic [RST_CNT_W-1:0] cnt_q;
    logic [RST_CNT_W-1:0] cnt_d;
    logic [1:0]           fsel_q;
    logic [1:0]           fsel_d;
    logic [1:0]           cfg_q;
    logic [1:0]           cfg_d;
    logic                 valid_q;
    logic                 valid_d;
    logic                 spd_q;
    logic                 spd_d;
    logic                 sus_q;
    logic                 sus_d;
    logic                 pol_lo_q;
    logic                 pol_lo_d;
    logic                 release_ev;

    // All pin inputs are synchronised before any logic looks at them.
    rsc_pin_sync #(
        .W (5)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .pin_in   ({ext_reset_n_pin, fixed_port_strap_hi,
                    fixed_port_strap_lo, config_method_strap_0,
                    config_method_strap_1}),
        .pin_sync (pins_s)
    );

    assign rpin_s = pins_s[4];
    assign hi_s   = pins_s[3];
    assign lo_s   = pins_s[2];
    assign cm0_s  = pins_s[1];
    assign cm1_s  = pins_s[0];

    // A release only counts after a full-length low pulse, so short glitches
    // on the reset pin neither reset the chip nor re-sample the straps.
    assign release_ev = (state_q == RSC_HELD) && rpin_s;

    // Sequencer: count the low time, then wait for the rising edge.
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            RSC_IDLE: begin
                cnt_d = '0;
                if (!rpin_s) begin
                    state_d = RSC_LOW;
                    cnt_d   = RST_CNT_W'(1);
                end
            end
            RSC_LOW: begin
                if (rpin_s) begin
                    state_d = RSC_IDLE;
                end else if (cnt_q >= RST_CNT_W'(RST_MIN_LOW_CYC - 1)) begin
                    state_d = RSC_HELD;
                end else begin
                    cnt_d = cnt_q + RST_CNT_W'(1);
                end
            end
            RSC_HELD: begin
                if (rpin_s) begin
                    state_d = RSC_IDLE;
                end
            end
            default: begin
                state_d = RSC_IDLE;
                cnt_d   = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= RSC_IDLE;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // Strap capture; latched straps change only at a qualified release, straps_valid clears while held.
    always_comb begin
        fsel_d   = fsel_q;
        cfg_d    = cfg_q;
        valid_d  = valid_q;
        pol_lo_d = pol_lo_q;
        if (state_q == RSC_HELD) begin
            valid_d = 1'b0;
        end
        if (release_ev) begin
            valid_d = 1'b1;
            cfg_d   = {cm1_s, cm0_s};
            if (fixed_strap_enable) begin
                fsel_d   = {hi_s, lo_s};
                pol_lo_d = lo_s;
            end else begin
                fsel_d   = FIXED_NONE;
                pol_lo_d = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fsel_q   <= FIXED_SEL_RST;
            cfg_q    <= CFG_METHOD_RST;
            valid_q  <= 1'b0;
            pol_lo_q <= 1'b0;
        end else begin
            fsel_q   <= fsel_d;
            cfg_q    <= cfg_d;
            valid_q  <= valid_d;
            pol_lo_q <= pol_lo_d;
        end
    end

    // selection decode
    // Ports beyond the package's count are never marked fixed.
    for (genvar p = 0; p < PORT_CNT; p++) begin : g_mask
        assign fixed_port_mask[p] = (p < int'(fsel_q)) &&
                                    (p <= int'(port_count_sel));
    end

    assign compound_device = (fsel_q != FIXED_NONE);

    // Indicator drive; the low fixed-port strap sets the suspend LED polarity.
    always_comb begin
        spd_d = hs_attached;
        sus_d = hub_active ^ pol_lo_q;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            spd_q <= 1'b0;
            sus_q <= 1'b0;
        end else begin
            spd_q <= spd_d;
            sus_q <= sus_d;
        end
    end

    // Pins stay undriven until straps are taken so they are not disturbed.
    assign chip_reset               = (state_q == RSC_HELD);
    assign straps_valid             = valid_q;
    assign config_method            = cfg_q;
    assign fixed_port_select        = fsel_q;
    assign upstream_speed_indicator = spd_q;
    assign speed_led_oe             = valid_q;
    assign suspend_indicator        = sus_q;
    assign suspend_led_oe           = valid_q;

    // Assertions.
    chk_release_latch: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        release_ev |=> (config_method == {$past(cm1_s), $past(cm0_s)}))
        else $error("method straps not latched at release");

    chk_fixed_gate: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (release_ev && !fixed_strap_enable) |=>
            (fixed_port_select == FIXED_NONE))
        else $error("fixed straps sampled while disabled");

    chk_fixed_sample: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (release_ev && fixed_strap_enable) |=>
            (fixed_port_select == {$past(hi_s), $past(lo_s)}))
        else $error("fixed selection not sampled");

    chk_mask_decode: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (fixed_port_select == FIXED_P12 && port_count_sel >= 2'h1) |->
            (fixed_port_mask[1:0] == 2'b11 && !fixed_port_mask[2]))
        else $error("fixed port decode wrong");

    chk_compound: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (fixed_port_mask != '0) |-> compound_device)
        else $error("compound not reported");

    chk_short_low: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(chip_reset) |-> !$past(rpin_s, 1) && !$past(rpin_s, 2))
        else $error("chip reset on short pulse");

    chk_speed_led: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        hs_attached |=> upstream_speed_indicator)
        else $error("speed indicator not asserted");

    chk_speed_off: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !hs_attached |=> !upstream_speed_indicator)
        else $error("speed indicator not negated");

    // The indicator register lags hub_active by one cycle.
    chk_led_pol: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (straps_valid && fixed_port_select[0]) |=>
            (suspend_indicator == !$past(hub_active)))
        else $error("led polarity wrong");

    chk_led_pol_hi: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (straps_valid && !fixed_port_select[0]) |=>
            (suspend_indicator == $past(hub_active)))
        else $error("active high led polarity wrong");

    chk_hold_straps: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!release_ev) |=>
            ($stable(config_method) && $stable(fixed_port_select)))
        else $error("straps changed without release");

    cov_release: cover property (
        @(posedge sys_clk) disable iff (!rst_n) release_ev);
    cov_compound: cover property (
        @(posedge sys_clk) disable iff (!rst_n) $rose(compound_device));
    cov_glitch: cover property (
        @(posedge sys_clk) disable iff (!rst_n)
        state_q == RSC_LOW ##1 state_q == RSC_IDLE);

endmodule

// *** testbench/rsc_board.sv ***
// Board model: strap pull resistors and the system reset driver.
// Assumes the bench asks for a reset pulse with a one-cycle start.
`timescale 1ns/1ps
module rsc_board (
    input  wire logic        sys_clk,
    input  wire logic        start,
    input  wire logic [15:0] low_len,
    input  wire logic [3:0]  pulls,
    output logic             ext_reset_n,
    output logic [3:0]       strap_pins
);
    logic [15:0] cnt_q  = 16'h0000;
    logic [2:0]  hold_q = 3'h0;
    logic [3:0]  tog_q  = 4'h0;

    always @(posedge sys_clk) begin
        tog_q <= ~strap_pins;
        if (start) begin
            cnt_q  <= low_len;
            hold_q <= 3'h5;
        end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
        end else if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
        end
    end

    assign ext_reset_n = (cnt_q == 16'h0000);
    // Pulls show only near reset; later the pins toggle as run-time I/O.
    assign strap_pins = (cnt_q != 16'h0000 || hold_q != 3'h0) ? pulls : tog_q;
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the reset strap capture block.
// Assumes rsc_board stands for the board; expectations go through a queue.
`timescale 1ns/1ps
module tb_top;
    logic       sys_clk, rst_n, start, fixed_strap_enable;
    logic       hs_attached = 1'b0;
    logic       hub_active  = 1'b0;
    logic       ext_reset_n_pin;
    logic       chip_reset, straps_valid, compound_device;
    logic       upstream_speed_indicator, speed_led_oe;
    logic       suspend_indicator, suspend_led_oe;
    logic       sv_prev  = 1'b0;
    logic       hs_prev  = 1'b0;
    logic       act_prev = 1'b0;
    logic [15:0] low_len;
    logic [1:0] port_count_sel, config_method, fixed_port_select;
    logic [3:0] pulls, strap_pins, fixed_port_mask;
    logic [7:0] notes_q[$];
    logic [7:0] cur_n, last_n;
    int         err_count, samples_checked;

    rsc_board i_board (.sys_clk, .start, .low_len, .pulls,
        .ext_reset_n(ext_reset_n_pin), .strap_pins);
    rsc_top i_dut (.sys_clk, .rst_n, .ext_reset_n_pin,
        .fixed_port_strap_hi(strap_pins[3]),
        .fixed_port_strap_lo(strap_pins[2]),
        .config_method_strap_1(strap_pins[1]),
        .config_method_strap_0(strap_pins[0]), .fixed_strap_enable,
        .port_count_sel, .hs_attached, .hub_active, .chip_reset, .straps_valid,
        .config_method, .fixed_port_select, .fixed_port_mask, .compound_device,
        .upstream_speed_indicator, .speed_led_oe, .suspend_indicator,
        .suspend_led_oe);

    // The bench clock stands in for the reference clock.
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic cmp(input logic [3:0] exp, input logic [3:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t exp %h got %h", $time, exp, got);
        end
    endtask

    task automatic results();
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Long pulses must raise chip_reset; short ones must not.
    // The board holds the pin low for len cycles; the check falls where a
    // long pulse has been seen long enough and a short one is still low.
    task automatic pulse(input int len);
        logic exp_rst;
        exp_rst = (len >= int'(rsc_pkg::RST_MIN_LOW_CYC));
        low_len <= 16'(len);
        start   <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        repeat (len - 4) @(posedge sys_clk);
        @(negedge sys_clk);
        cmp({3'h0, chip_reset}, {3'h0, exp_rst});
        repeat (16) @(posedge sys_clk);
    endtask

    // Run-time inputs take a new random value every cycle to catch stale indicators; they stay
    // low through the power-on reset so the first checks see known values.
    always @(posedge sys_clk) begin
        if (rst_n) begin
            hs_attached <= 1'($urandom);
            hub_active  <= 1'($urandom);
        end
    end

    // Each capture pops the oldest note; indicators are checked every cycle that straps_valid stays high.
    // Sampling on the falling edge sees every output settled.
    always @(negedge sys_clk) begin
        sv_prev  <= straps_valid;
        hs_prev  <= hs_attached;
        act_prev <= hub_active;
        if (straps_valid === 1'b1 && sv_prev === 1'b0) begin
            cmp(4'h1, {3'h0, notes_q.size() != 0});
            cur_n = notes_q.pop_front();
            cmp({config_method, fixed_port_select}, cur_n[7:4]);
            cmp(fixed_port_mask, cur_n[3:0]);
            cmp({3'h0, compound_device}, {3'h0, cur_n[5:4] != 2'h0});
        end
        if (straps_valid === 1'b1 && sv_prev === 1'b1) begin
            cmp({3'h0, suspend_indicator}, {3'h0, act_prev ^ cur_n[4]});
            cmp({3'h0, upstream_speed_indicator}, {3'h0, hs_prev});
            cmp({2'h0, speed_led_oe, suspend_led_oe}, 4'h3);
        end
    end

    initial begin
        repeat (10000) @(posedge sys_clk);
        err_count++;
        results();
    end

    initial begin
        logic [3:0] p;
        logic [1:0] c, sel;
        logic       e;
        void'($urandom(58));
        {rst_n, start, fixed_strap_enable} = '0;
        port_count_sel = 2'h0;
        low_len = 16'h0000;
        pulls = 4'h0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        // Disabled straps first, then every strap pattern enabled.
        for (int i = 0; i < 20; i++) begin
            p   = 4'(i * 7);
            e   = (i >= 4);
            c   = 2'($urandom);
            sel = e ? p[3:2] : 2'h0;
            last_n = {p[1:0], sel, 4'((5'h02 << c) - 5'h01) &
                      {1'b0, sel == 2'h3, sel[1], sel != 2'h0}};
            notes_q.push_back(last_n);
            pulls              <= p;
            fixed_strap_enable <= e;
            port_count_sel     <= c;
            pulse(260);
        end
        // A short pulse with new pulls must leave the capture alone.
        pulls <= ~pulls;
        pulse(200);
        cmp({config_method, fixed_port_select}, last_n[7:4]);
        cmp(fixed_port_mask, last_n[3:0]);
        cmp(4'h0, 4'(notes_q.size()));
        results();
    end
endmodule
